// ==== rtl/arlt_defs.svh ====
`ifndef ARLT_DEFS_SVH
`define ARLT_DEFS_SVH

// ****************************************************************
// Register addresses on the special-function register bus
// ****************************************************************
`define ARLT_A_CTRL_ADDR 8'hc8
`define ARLT_A_RLL_ADDR 8'hca
`define ARLT_A_RLH_ADDR 8'hcb
`define ARLT_A_CL_ADDR 8'hcc
`define ARLT_A_CH_ADDR 8'hcd
`define ARLT_B_CTRL_ADDR 8'h91
`define ARLT_B_RLL_ADDR 8'h92
`define ARLT_B_RLH_ADDR 8'h93
`define ARLT_B_CL_ADDR 8'h94
`define ARLT_B_CH_ADDR 8'h95

// ****************************************************************
// Control register field positions
// ****************************************************************
`define ARLT_BIT_HIGH_FLAG 7
`define ARLT_BIT_LOW_FLAG 6
`define ARLT_BIT_LOW_IRQ_EN 5
`define ARLT_BIT_CAPTURE_EN 4
`define ARLT_BIT_SPLIT 3
`define ARLT_BIT_RUN 2
`define ARLT_BITS_XCLK 1:0

// ****************************************************************
// Reset values and clock divisions
// ****************************************************************
`define ARLT_RESET_BYTE 8'h00
`define ARLT_SYS_DIV 4'hc
`define ARLT_EXT_DIV 4'h8

`endif

// ==== rtl/arlt_pkg.sv ====
package arlt_pkg;

   // Control register layout, most significant field first.
   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_overflow_irq_enable;
      logic capture_enable;
      logic split_mode_enable;
      logic run_control;
      logic [1:0] ext_clock_select;
   } arlt_ctrl_t;

   // Single-cycle tick pulses in the system clock domain.
   typedef struct packed {
      logic sys_div12;
      logic ext_div8;
      logic rtc_edge;
   } arlt_ticks_t;

   typedef enum logic [2:0] {
      ARLT_REG_CTRL,
      ARLT_REG_RLL,
      ARLT_REG_RLH,
      ARLT_REG_CL,
      ARLT_REG_CH
   } arlt_reg_t;

   // Register bus request carrier.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } arlt_sfr_req_t;

endpackage

// ==== rtl/arlt_clk_src.sv ====
`include "arlt_defs.svh"

module arlt_clk_src
   import arlt_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_osc_in,
   input wire logic rtc_in,
   output arlt_ticks_t ticks
);

   // ****************************************************************
   // Synchronisers and edge detection
   // ****************************************************************
   logic [2:0] ext_sync_q, ext_sync_d;
   logic [2:0] rtc_sync_q, rtc_sync_d;
   logic [3:0] sys_cnt_q, sys_cnt_d;
   logic [3:0] ext_cnt_q, ext_cnt_d;
   arlt_ticks_t ticks_d;
   logic ext_rise;

   always_comb begin
      ext_sync_d = {ext_sync_q[1:0], ext_osc_in};
      rtc_sync_d = {rtc_sync_q[1:0], rtc_in};
      ext_rise = ext_sync_q[1] && !ext_sync_q[2];
      ticks_d = '0;
      if (sys_cnt_q == `ARLT_SYS_DIV - 4'h1) begin
         sys_cnt_d = 4'h0;
         ticks_d.sys_div12 = 1'b1;
      end else begin
         sys_cnt_d = sys_cnt_q + 4'h1;
      end
      ext_cnt_d = ext_cnt_q;
      if (ext_rise) begin
         if (ext_cnt_q == `ARLT_EXT_DIV - 4'h1) begin
            ext_cnt_d = 4'h0;
            ticks_d.ext_div8 = 1'b1;
         end else begin
            ext_cnt_d = ext_cnt_q + 4'h1;
         end
      end
      ticks_d.rtc_edge = rtc_sync_q[1] && !rtc_sync_q[2];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_sync_q <= 3'h0;
         rtc_sync_q <= 3'h0;
         sys_cnt_q <= 4'h0;
         ext_cnt_q <= 4'h0;
         ticks <= '0;
      end else begin
         ext_sync_q <= ext_sync_d;
         rtc_sync_q <= rtc_sync_d;
         sys_cnt_q <= sys_cnt_d;
         ext_cnt_q <= ext_cnt_d;
         ticks <= ticks_d;
      end
   end

endmodule

// ==== rtl/arlt_timer.sv ====
`include "arlt_defs.svh"

module arlt_timer
   import arlt_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input arlt_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   output logic sfr_rvalid,
   input wire logic ext_osc_in,
   input wire logic rtc_in,
   input wire logic [1:0] timer_irq_enable,
   input wire logic [1:0] low_byte_clock_choice,
   input wire logic [1:0] high_byte_clock_choice,
   output logic [1:0] timer_irq
);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic logic [7:0] addr_of(input logic t, input arlt_reg_t r);
      logic [7:0] a;
      a = 8'h00;
      unique case (r)
         ARLT_REG_CTRL: a = t ? `ARLT_B_CTRL_ADDR : `ARLT_A_CTRL_ADDR;
         ARLT_REG_RLL: a = t ? `ARLT_B_RLL_ADDR : `ARLT_A_RLL_ADDR;
         ARLT_REG_RLH: a = t ? `ARLT_B_RLH_ADDR : `ARLT_A_RLH_ADDR;
         ARLT_REG_CL: a = t ? `ARLT_B_CL_ADDR : `ARLT_A_CL_ADDR;
         ARLT_REG_CH: a = t ? `ARLT_B_CH_ADDR : `ARLT_A_CH_ADDR;
      endcase
      return a;
   endfunction

   function automatic logic hit(input logic t, input arlt_reg_t r, input logic [7:0] a);
      return a == addr_of(t, r);
   endfunction

   // Count source: code 01 is the external oscillator, all others system clock.
   function automatic logic count_src(input logic [1:0] sel, input arlt_ticks_t tk);
      return (sel == 2'b01) ? tk.ext_div8 : tk.sys_div12;
   endfunction

   // Capture source: code 10 is the external oscillator, all others the RTC.
   function automatic logic capture_src(input logic [1:0] sel, input arlt_ticks_t tk);
      return (sel == 2'b10) ? tk.ext_div8 : tk.rtc_edge;
   endfunction

   // ****************************************************************
   // Clock sources
   // ****************************************************************
   arlt_ticks_t ticks;

   arlt_clk_src u_clk_src (
      .clk(clk),
      .rst(rst),
      .ext_osc_in(ext_osc_in),
      .rtc_in(rtc_in),
      .ticks(ticks)
   );

   // ****************************************************************
   // Timer state
   // ****************************************************************
   arlt_ctrl_t ctl_q [2];
   arlt_ctrl_t ctl_d [2];
   logic [7:0] cl_q [2];
   logic [7:0] cl_d [2];
   logic [7:0] ch_q [2];
   logic [7:0] ch_d [2];
   logic [7:0] rl_q [2];
   logic [7:0] rl_d [2];
   logic [7:0] rh_q [2];
   logic [7:0] rh_d [2];
   logic tl_w [2];
   logic th_w [2];
   logic cap_w [2];
   logic [1:0] irq_d;

   always_comb begin
      for (int t = 0; t < 2; t++) begin
         logic ext;
         ext = count_src(ctl_q[t].ext_clock_select, ticks);
         tl_w[t] = low_byte_clock_choice[t] ? 1'b1 : ext;
         th_w[t] = high_byte_clock_choice[t] ? 1'b1 : ext;
         cap_w[t] = ctl_q[t].capture_enable
                    && capture_src(ctl_q[t].ext_clock_select, ticks);
      end
   end

   always_comb begin
      for (int t = 0; t < 2; t++) begin
         logic set_h;
         logic set_l;
         logic [15:0] cnt;
         logic tb;
         set_h = 1'b0;
         set_l = 1'b0;
         tb = t[0];
         cnt = {ch_q[t], cl_q[t]};
         ctl_d[t] = ctl_q[t];
         cl_d[t] = cl_q[t];
         ch_d[t] = ch_q[t];
         rl_d[t] = rl_q[t];
         rh_d[t] = rh_q[t];
         if (ctl_q[t].split_mode_enable) begin
            if (tl_w[t]) begin
               if (cl_q[t] == 8'hff) begin
                  cl_d[t] = rl_q[t];
                  set_l = 1'b1;
               end else begin
                  cl_d[t] = cl_q[t] + 8'h01;
               end
            end
            if (ctl_q[t].run_control && th_w[t]) begin
               if (ch_q[t] == 8'hff) begin
                  ch_d[t] = rh_q[t];
                  set_h = 1'b1;
               end else begin
                  ch_d[t] = ch_q[t] + 8'h01;
               end
            end
         end else if (ctl_q[t].run_control && tl_w[t]) begin
            if (cnt == 16'hffff) begin
               cl_d[t] = rl_q[t];
               ch_d[t] = rh_q[t];
               set_h = 1'b1;
               set_l = 1'b1;
            end else begin
               {ch_d[t], cl_d[t]} = cnt + 16'h0001;
               set_l = (cl_q[t] == 8'hff);
            end
         end
         // Software writes to the count bytes take precedence over counting.
         if (sfr_req.wr) begin
            if (hit(tb, ARLT_REG_CTRL, sfr_req.addr)) begin
               ctl_d[t] = arlt_ctrl_t'(sfr_req.wdata);
            end
            if (hit(tb, ARLT_REG_CL, sfr_req.addr)) begin
               cl_d[t] = sfr_req.wdata;
            end
            if (hit(tb, ARLT_REG_CH, sfr_req.addr)) begin
               ch_d[t] = sfr_req.wdata;
            end
            if (hit(tb, ARLT_REG_RLL, sfr_req.addr)) begin
               rl_d[t] = sfr_req.wdata;
            end
            if (hit(tb, ARLT_REG_RLH, sfr_req.addr)) begin
               rh_d[t] = sfr_req.wdata;
            end
         end
         // A capture beats a software write to the reload pair.
         if (cap_w[t]) begin
            rl_d[t] = cl_q[t];
            rh_d[t] = ch_q[t];
            set_h = 1'b1;
         end
         // Hardware set wins over a software clear in the same cycle.
         if (set_h) begin
            ctl_d[t].high_overflow_flag = 1'b1;
         end
         if (set_l) begin
            ctl_d[t].low_overflow_flag = 1'b1;
         end
      end
   end

   always_comb begin
      for (int t = 0; t < 2; t++) begin
         irq_d[t] = timer_irq_enable[t] && (ctl_q[t].high_overflow_flag
                    || (ctl_q[t].low_overflow_flag && ctl_q[t].low_overflow_irq_enable));
      end
   end

   assign timer_irq = irq_d;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int t = 0; t < 2; t++) begin
            ctl_q[t] <= arlt_ctrl_t'(`ARLT_RESET_BYTE);
            cl_q[t] <= `ARLT_RESET_BYTE;
            ch_q[t] <= `ARLT_RESET_BYTE;
            rl_q[t] <= `ARLT_RESET_BYTE;
            rh_q[t] <= `ARLT_RESET_BYTE;
         end
      end else begin
         for (int t = 0; t < 2; t++) begin
            ctl_q[t] <= ctl_d[t];
            cl_q[t] <= cl_d[t];
            ch_q[t] <= ch_d[t];
            rl_q[t] <= rl_d[t];
            rh_q[t] <= rh_d[t];
         end
      end
   end

   // ****************************************************************
   // Register read port
   // ****************************************************************
   logic [7:0] rdata_d;

   always_comb begin
      rdata_d = 8'h00;
      for (int t = 0; t < 2; t++) begin
         if (hit(t[0], ARLT_REG_CTRL, sfr_req.addr)) begin
            rdata_d = ctl_q[t];
         end
         if (hit(t[0], ARLT_REG_RLL, sfr_req.addr)) begin
            rdata_d = rl_q[t];
         end
         if (hit(t[0], ARLT_REG_RLH, sfr_req.addr)) begin
            rdata_d = rh_q[t];
         end
         if (hit(t[0], ARLT_REG_CL, sfr_req.addr)) begin
            rdata_d = cl_q[t];
         end
         if (hit(t[0], ARLT_REG_CH, sfr_req.addr)) begin
            rdata_d = ch_q[t];
         end
      end
      if (!sfr_req.rd) begin
         rdata_d = 8'h00;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
         sfr_rvalid <= 1'b0;
      end else begin
         sfr_rdata <= rdata_d;
         sfr_rvalid <= sfr_req.rd;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   for (genvar g = 0; g < 2; g++) begin : g_chk
      logic wr_t;
      assign wr_t = sfr_req.wr && (hit(1'(g), ARLT_REG_CTRL, sfr_req.addr)
                    || hit(1'(g), ARLT_REG_RLL, sfr_req.addr)
                    || hit(1'(g), ARLT_REG_RLH, sfr_req.addr)
                    || hit(1'(g), ARLT_REG_CL, sfr_req.addr)
                    || hit(1'(g), ARLT_REG_CH, sfr_req.addr));

      sequence s_wrap16;
         !ctl_q[g].split_mode_enable && ctl_q[g].run_control && tl_w[g]
         && {ch_q[g], cl_q[g]} == 16'hffff && !wr_t && !cap_w[g];
      endsequence

      sequence s_low_wrap_split;
         ctl_q[g].split_mode_enable && tl_w[g] && cl_q[g] == 8'hff && !wr_t && !cap_w[g];
      endsequence

      a_wrap16_reload: assert property (s_wrap16 |=> ctl_q[g].high_overflow_flag
         && ctl_q[g].low_overflow_flag && {ch_q[g], cl_q[g]} == $past({rh_q[g], rl_q[g]}))
         else $error("16-bit wrap did not reload and flag");
      a_split_low_reload: assert property (s_low_wrap_split |=>
         cl_q[g] == $past(rl_q[g]) && ctl_q[g].low_overflow_flag)
         else $error("split low byte did not reload");
      a_low_wrap16_flag: assert property (!ctl_q[g].split_mode_enable
         && ctl_q[g].run_control && tl_w[g] && cl_q[g] == 8'hff && !wr_t
         |=> ctl_q[g].low_overflow_flag)
         else $error("16-bit low byte wrap left low flag clear");
      a_split_high_reload: assert property (ctl_q[g].split_mode_enable
         && ctl_q[g].run_control && th_w[g] && ch_q[g] == 8'hff && !wr_t
         |=> ch_q[g] == $past(rh_q[g]) && ctl_q[g].high_overflow_flag)
         else $error("split high byte did not reload");
      a_capture_low_copy: assert property (cap_w[g] |=> rl_q[g] == $past(cl_q[g]))
         else $error("capture lost low byte");
      a_capture_high_copy: assert property (cap_w[g]
         |=> rh_q[g] == $past(ch_q[g]) && ctl_q[g].high_overflow_flag)
         else $error("capture lost high byte");
      a_split_low_free: assert property (ctl_q[g].split_mode_enable && !ctl_q[g].run_control
         && tl_w[g] && cl_q[g] != 8'hff && !wr_t |=> cl_q[g] == $past(cl_q[g]) + 8'h01)
         else $error("split low byte stalled");
      a_high_stop_hold: assert property (!ctl_q[g].run_control && !wr_t
         |=> $stable(ch_q[g]))
         else $error("high byte moved while stopped");
      a_high_flag_sticky: assert property (ctl_q[g].high_overflow_flag && !wr_t
         |=> ctl_q[g].high_overflow_flag)
         else $error("high flag cleared by hardware");
      a_irq_high_flag: assert property (timer_irq_enable[g] && ctl_q[g].high_overflow_flag
         |-> timer_irq[g])
         else $error("missing high overflow interrupt");
      a_irq_low_flag: assert property (timer_irq[g] |-> timer_irq_enable[g]
         && (ctl_q[g].high_overflow_flag
         || (ctl_q[g].low_overflow_flag && ctl_q[g].low_overflow_irq_enable)))
         else $error("spurious timer interrupt");
   end

endmodule

// ==== verif/tb.sv ====
`include "arlt_defs.svh"

module tb
   import arlt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst = 1'b1;
   arlt_sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic sfr_rvalid;
   logic ext_osc_in = 1'b0;
   logic rtc_in = 1'b0;
   logic [1:0] timer_irq_enable = 2'b00;
   logic [1:0] low_byte_clock_choice = 2'b00;
   logic [1:0] high_byte_clock_choice = 2'b00;
   logic [1:0] timer_irq;
   int fails = 0;
   int compares = 0;
   logic [7:0] exp_q[$];
   logic [7:0] rnd_a;
   logic [7:0] rnd_b;
   logic [7:0] k;
   logic [7:0] regs[11] = '{`ARLT_A_CTRL_ADDR, `ARLT_A_RLL_ADDR, `ARLT_A_RLH_ADDR,
      `ARLT_A_CL_ADDR, `ARLT_A_CH_ADDR, `ARLT_B_CTRL_ADDR, `ARLT_B_RLL_ADDR,
      `ARLT_B_RLH_ADDR, `ARLT_B_CL_ADDR, `ARLT_B_CH_ADDR, 8'h96};

   always #4 clk = ~clk;

   arlt_timer arlt_timer_inst (
      .clk(clk),
      .rst(rst),
      .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata),
      .sfr_rvalid(sfr_rvalid),
      .ext_osc_in(ext_osc_in),
      .rtc_in(rtc_in),
      .timer_irq_enable(timer_irq_enable),
      .low_byte_clock_choice(low_byte_clock_choice),
      .high_byte_clock_choice(high_byte_clock_choice),
      .timer_irq(timer_irq)
   );

   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] expv);
      compares++;
      if (seen !== expv) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic report_and_stop;
      if (fails == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Read data stands for one cycle, so it is taken at the falling edge after it rises.
   always @(negedge clk) begin
      if (sfr_rvalid === 1'b1) begin
         check(sfr_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
      end
   end

   // ****************************************************************
   // Register bus and pin drivers
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      sfr_req = '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      exp_q.push_back(e);
      @(negedge clk);
      sfr_req = '0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Pulses are long enough for the two-stage synchroniser to see every edge.
   task automatic pulse(input bit is_rtc, input int n);
      repeat (n) begin
         @(negedge clk);
         if (is_rtc) rtc_in = 1'b1;
         else ext_osc_in = 1'b1;
         idle(3);
         if (is_rtc) rtc_in = 1'b0;
         else ext_osc_in = 1'b0;
         idle(3);
      end
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(32'h3ef48538));
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      foreach (regs[i]) begin
         rd(regs[i], `ARLT_RESET_BYTE);
      end
      rnd_a = 8'($urandom());
      rnd_b = 8'($urandom());
      wr(`ARLT_A_RLL_ADDR, rnd_a);
      wr(`ARLT_A_RLH_ADDR, rnd_b);
      rd(`ARLT_A_RLL_ADDR, rnd_a);
      rd(`ARLT_A_RLH_ADDR, rnd_b);

      // Timer B as one 16-bit counter ticking every clock, wrapping once.
      wr(`ARLT_B_RLL_ADDR, 8'h34);
      wr(`ARLT_B_RLH_ADDR, 8'h12);
      wr(`ARLT_B_CL_ADDR, 8'hfe);
      wr(`ARLT_B_CH_ADDR, 8'hff);
      timer_irq_enable = 2'b10;
      low_byte_clock_choice = 2'b10;
      high_byte_clock_choice = 2'b10;
      wr(`ARLT_B_CTRL_ADDR, 8'h04);
      idle(20);
      rd(`ARLT_B_CH_ADDR, 8'h12);
      rd(`ARLT_B_CTRL_ADDR, 8'hc4);
      check({7'h00, timer_irq[1]}, 8'h01);
      wr(`ARLT_B_CTRL_ADDR, 8'h04);
      idle(2);
      rd(`ARLT_B_CTRL_ADDR, 8'h04);
      check({7'h00, timer_irq[1]}, 8'h00);

      // Split mode: the low byte runs with run control off while the high byte holds, then the high byte wraps with run on.
      wr(`ARLT_B_CTRL_ADDR, 8'h28);
      wr(`ARLT_B_CL_ADDR, 8'hfd);
      wr(`ARLT_B_CH_ADDR, 8'hf0);
      idle(20);
      rd(`ARLT_B_CTRL_ADDR, 8'h68);
      check({7'h00, timer_irq[1]}, 8'h01);
      rd(`ARLT_B_CH_ADDR, 8'hf0);
      wr(`ARLT_B_CH_ADDR, 8'hff);
      wr(`ARLT_B_CTRL_ADDR, 8'h2c);
      idle(20);
      rd(`ARLT_B_CTRL_ADDR, 8'hac);

      // Capture on timer A for every clock select code; only code 10 captures on ext/8.
      timer_irq_enable = 2'b11;
      for (k = 8'h00; k < 8'h04; k++) begin
         wr(`ARLT_A_CTRL_ADDR, 8'h10 | k);
         wr(`ARLT_A_CL_ADDR, 8'h40 + k);
         wr(`ARLT_A_CH_ADDR, 8'h50 + k);
         pulse(1'b1, 1);
         idle(8);
         wr(`ARLT_A_CL_ADDR, 8'h60 + k);
         pulse(1'b0, 8);
         idle(8);
         rd(`ARLT_A_RLL_ADDR, (k == 8'h02) ? 8'h60 + k : 8'h40 + k);
         rd(`ARLT_A_RLH_ADDR, 8'h50 + k);
         rd(`ARLT_A_CTRL_ADDR, 8'h90 | k);
         check({7'h00, timer_irq[0]}, 8'h01);
      end

      // Timer A in 16-bit mode: code 11 counts the divided system clock, code 01 the oscillator.
      wr(`ARLT_A_CTRL_ADDR, 8'h07);
      wr(`ARLT_A_CH_ADDR, 8'h00);
      wr(`ARLT_A_CL_ADDR, 8'h00);
      // Thirty-six count edges between write and read hold exactly three ticks.
      idle(35);
      rd(`ARLT_A_CL_ADDR, 8'h03);
      wr(`ARLT_A_CTRL_ADDR, 8'h05);
      wr(`ARLT_A_CH_ADDR, 8'h00);
      wr(`ARLT_A_CL_ADDR, 8'hfe);
      pulse(1'b0, 16);
      rd(`ARLT_A_CL_ADDR, 8'h00);
      rd(`ARLT_A_CH_ADDR, 8'h01);
      rd(`ARLT_A_CTRL_ADDR, 8'h45);
      check({7'h00, timer_irq[0]}, 8'h00);
      idle(4);
      check(8'(exp_q.size()), 8'h00);
      report_and_stop();
   end

   initial begin
      #(8ns * 5000);
      fails++;
      report_and_stop();
   end
endmodule
